// ===== rtl/fuse_lock_pkg.sv
// Shared constants and types for the fuse and lock readback block.
// Assumes a single 250 MHz core clock and an 8-bit CPU data path.
package fuse_lock_pkg;

  // Program-memory control register field positions
  localparam int CTRL_W = 5;
  localparam int CTRL_SELF_PROG_BIT = 0;
  localparam int CTRL_PAGE_ERASE_BIT = 1;
  localparam int CTRL_PAGE_WRITE_BIT = 2;
  localparam int CTRL_FUSE_READ_BIT = 3;
  localparam int CTRL_CLEAR_BUF_BIT = 4;

  // The only control codes that take effect when written, then the idle value
  localparam logic [4:0] CMD_BUF_CLEAR = 5'h11;
  localparam logic [4:0] CMD_READ_CFG = 5'h09;
  localparam logic [4:0] CMD_PAGE_WRITE = 5'h05;
  localparam logic [4:0] CMD_PAGE_ERASE = 5'h03;
  localparam logic [4:0] CMD_BUF_FILL = 5'h01;
  localparam logic [4:0] CTRL_IDLE = 5'h00;

  // Acceptance windows in cycles after the control write
  localparam logic [2:0] LOAD_WINDOW = 3'h3;
  localparam logic [2:0] STORE_WINDOW = 3'h4;

  // Pointer values that select a configuration byte on readback
  localparam logic [15:0] ADDR_LOW_FUSE = 16'h0000;
  localparam logic [15:0] ADDR_LOCK = 16'h0001;
  localparam logic [15:0] ADDR_HIGH_FUSE = 16'h0003;

  // Bit positions; zero means programmed throughout
  localparam int LOCK_LOW_BIT = 0;
  localparam int LOCK_HIGH_BIT = 1;
  localparam int SELF_PROG_FUSE_BIT = 0;
  localparam int SERIAL_PROG_FUSE_BIT = 5;
  localparam int DEBUG_LINK_BIT = 7;

  // Erased and default values
  localparam logic [7:0] UNPROG_BYTE = 8'hff;
  localparam logic [7:0] LOCK_UNUSED_ONES = 8'hfc;
  localparam logic [1:0] LOCK_ERASED = 2'h3;
  localparam logic [7:0] FUSE_EXT_DEFAULT = 8'hff;
  localparam logic [7:0] FUSE_HIGH_DEFAULT = 8'hdf;
  localparam logic [7:0] FUSE_LOW_DEFAULT = 8'h64;

  // Non-volatile write time, least figure, rounded up to cycles
  localparam real CLK_MHZ = 250.0;
  localparam real NV_WRITE_MIN_MS = 3.7;
  localparam real NV_WRITE_MAX_MS = 4.5;
  localparam int NV_WRITE_CYCLES = int'($ceil(NV_WRITE_MIN_MS * 1000.0 * CLK_MHZ));
  typedef logic [20:0] nv_cnt_t;

  typedef enum logic [1:0] {FUSE_SEL_LOW, FUSE_SEL_HIGH, FUSE_SEL_EXT} fuse_sel_t;
  typedef enum logic [1:0] {NV_IDLE, NV_ERASE, NV_WRITE, NV_LOCK} nv_op_t;

  // Lock bits can only move towards programmed (zero)
  function automatic logic [1:0] lock_program(input logic [1:0] old_bits,
                                              input logic [1:0] req_bits);
    lock_program = old_bits & req_bits;
  endfunction

endpackage

// ===== rtl/cmd_window.sv
// Countdown that keeps a control command open for a few cycles.
// Assumes start, close and len come from logic on core_clk.
`timescale 1ns/1ps
module cmd_window (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic clk_en,
  input wire logic start,
  input wire logic [2:0] len,
  input wire logic close,
  output logic open,
  output logic expire
);
  typedef struct packed {
    logic [2:0] count; // Cycles left in the window
  } window_state_t;

  window_state_t cur;
  window_state_t next_cur;

  // Load on start, drop on close, otherwise count down
  always_comb begin
    next_cur = cur;
    if (start) begin
      next_cur.count = len;
    end else if (close) begin
      next_cur.count = 3'h0;
    end else if (cur.count != 3'h0) begin
      next_cur.count = cur.count - 3'h1;
    end
  end

  // Last open cycle passing with nothing taken
  assign open = cur.count != 3'h0;
  assign expire = (cur.count == 3'h1) && !start && !close;

  // Register the state
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      cur <= '0;
    end else if (clk_en) begin
      cur <= next_cur;
    end
  end
endmodule

// ===== rtl/nv_config.sv
// Non-volatile fuse and lock cells plus the self-write timer.
// Assumes power_on_rst_n only pulses at power-up; core reset never reaches it.
`timescale 1ns/1ps
module nv_config #(
  parameter int WRITE_CYCLES = fuse_lock_pkg::NV_WRITE_CYCLES
) (
  input wire logic core_clk,
  input wire logic power_on_rst_n,
  input wire logic clk_en,
  input wire fuse_lock_pkg::nv_op_t start_op,
  input wire logic [1:0] lock_data,
  input wire logic prog_fuse_wr,
  input wire fuse_lock_pkg::fuse_sel_t prog_fuse_sel,
  input wire logic prog_serial,
  input wire logic [7:0] prog_data,
  input wire logic prog_lock_wr,
  input wire logic prog_chip_erase,
  output logic [7:0] lock_byte,
  output logic [7:0] fuse_low,
  output logic [7:0] fuse_high,
  output logic [7:0] fuse_ext,
  output logic busy,
  output logic done
);
  typedef struct packed {
    logic [1:0] lock; // Lock bits, zero is programmed
    logic [1:0] pend; // Lock value waiting for its write to finish
    logic [7:0] low;
    logic [7:0] high;
    logic [7:0] ext;
    fuse_lock_pkg::nv_op_t op; // Write in flight
    fuse_lock_pkg::nv_cnt_t count; // Cycles left of the write
  } nv_state_t;

  localparam nv_state_t NV_RESET = '{lock: fuse_lock_pkg::LOCK_ERASED,
                                     pend: fuse_lock_pkg::LOCK_ERASED,
                                     low: fuse_lock_pkg::FUSE_LOW_DEFAULT,
                                     high: fuse_lock_pkg::FUSE_HIGH_DEFAULT,
                                     ext: fuse_lock_pkg::FUSE_EXT_DEFAULT,
                                     op: fuse_lock_pkg::NV_IDLE,
                                     count: '0};

  nv_state_t cur;
  nv_state_t next_cur;

  // Timed self-write, then programming-party operations
  always_comb begin
    next_cur = cur;
    if (cur.op != fuse_lock_pkg::NV_IDLE) begin
      if (cur.count == fuse_lock_pkg::nv_cnt_t'(1)) begin
        if (cur.op == fuse_lock_pkg::NV_LOCK) begin
          next_cur.lock = fuse_lock_pkg::lock_program(cur.lock, cur.pend);
        end
        next_cur.op = fuse_lock_pkg::NV_IDLE;
        next_cur.count = '0;
      end else begin
        next_cur.count = cur.count - fuse_lock_pkg::nv_cnt_t'(1);
      end
    end else if (start_op != fuse_lock_pkg::NV_IDLE) begin
      next_cur.op = start_op;
      next_cur.count = fuse_lock_pkg::nv_cnt_t'(WRITE_CYCLES);
      next_cur.pend = lock_data;
    end
    // Erase only releases the lock bits; fuses are untouched
    if (prog_chip_erase) begin
      next_cur.lock = fuse_lock_pkg::LOCK_ERASED;
    end else if (prog_lock_wr) begin
      next_cur.lock = fuse_lock_pkg::lock_program(cur.lock, prog_data[1:0]);
    end
    // Any programmed low lock bit freezes every fuse byte
    if (prog_fuse_wr && cur.lock[fuse_lock_pkg::LOCK_LOW_BIT]) begin
      unique case (prog_fuse_sel)
        fuse_lock_pkg::FUSE_SEL_LOW: next_cur.low = prog_data;
        fuse_lock_pkg::FUSE_SEL_HIGH: begin
          next_cur.high = prog_data;
          if (prog_serial) begin
            // Serial path cannot lock itself out
            next_cur.high[fuse_lock_pkg::SERIAL_PROG_FUSE_BIT] =
              cur.high[fuse_lock_pkg::SERIAL_PROG_FUSE_BIT];
          end
        end
        fuse_lock_pkg::FUSE_SEL_EXT: next_cur.ext = prog_data;
        default: ;
      endcase
    end
  end

  // Unused lock positions read as unprogrammed
  assign lock_byte = fuse_lock_pkg::LOCK_UNUSED_ONES | {6'h00, cur.lock};
  assign fuse_low = cur.low;
  assign fuse_high = cur.high;
  assign fuse_ext = cur.ext;
  assign busy = cur.op != fuse_lock_pkg::NV_IDLE;
  assign done = busy && (cur.count == fuse_lock_pkg::nv_cnt_t'(1));

  // Only power-up clears this state, so a core reset lets a write finish
  always_ff @(posedge core_clk) begin
    if (!power_on_rst_n) begin
      cur <= NV_RESET;
    end else if (clk_en) begin
      cur <= next_cur;
    end
  end
endmodule

// ===== rtl/fuse_lock_readback_protect.sv
// Fuse and lock readback, protection decode and control register.
// Assumes the CPU pulses load_req/store_req for one cycle per instruction
// and presents the ordinary flash byte on flash_rdata in that cycle.
`timescale 1ns/1ps
module fuse_lock_readback_protect #(
  parameter int NV_WRITE_CYCLES = fuse_lock_pkg::NV_WRITE_CYCLES
) (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic power_on_rst_n,
  input wire logic clk_en,
  input wire logic ctrl_wr,
  input wire logic [7:0] ctrl_wdata,
  output logic [7:0] ctrl_rdata,
  input wire logic load_req,
  input wire logic [15:0] load_addr,
  input wire logic [7:0] flash_rdata,
  output logic [7:0] load_data,
  output logic load_valid,
  output logic load_from_config,
  input wire logic store_req,
  input wire logic [7:0] store_data,
  output logic page_buffer_fill,
  output logic page_buffer_clear,
  output logic cpu_halt,
  input wire logic eeprom_write_busy,
  input wire logic prog_fuse_wr,
  input wire fuse_lock_pkg::fuse_sel_t prog_fuse_sel,
  input wire logic prog_serial,
  input wire logic [7:0] prog_data,
  input wire logic prog_lock_wr,
  input wire logic prog_chip_erase,
  output logic [7:0] lock_byte,
  output logic [7:0] fuse_low,
  output logic [7:0] fuse_high,
  output logic [7:0] fuse_ext,
  output logic flash_prog_allow,
  output logic flash_verify_allow,
  output logic fuse_change_allow,
  output logic clock_keep_in_sleep,
  output logic self_program_allowed
);
  typedef struct packed {
    logic [4:0] ctrl; // Program-memory control register
    logic [7:0] load_data; // Byte returned to the destination register
    logic load_valid;
    logic load_cfg; // Returned byte came from configuration
    logic fill; // Page buffer word store pulse
    logic clr; // Page buffer clear pulse
  } main_state_t;

  main_state_t cur;
  main_state_t next_cur;

  logic win_open; // Command window still accepting
  logic win_expire; // Window ends this edge unused
  logic win_start;
  logic win_close;
  logic [2:0] win_len;
  logic nv_busy;
  logic nv_done;
  fuse_lock_pkg::nv_op_t nv_start;
  logic cmd_valid;
  logic ctrl_accept;
  logic read_armed;
  logic finish;

  // Write command window for the control register
  cmd_window cmd_window_inst (
    .core_clk(core_clk),
    .rst_n(rst_n),
    .clk_en(clk_en),
    .start(win_start),
    .len(win_len),
    .close(win_close),
    .open(win_open),
    .expire(win_expire)
  );

  // Fuse and lock cells with the write timer
  nv_config #(
    .WRITE_CYCLES(NV_WRITE_CYCLES)
  ) nv_config_inst (
    .core_clk(core_clk),
    .power_on_rst_n(power_on_rst_n),
    .clk_en(clk_en),
    .start_op(nv_start),
    .lock_data(store_data[1:0]),
    .prog_fuse_wr(prog_fuse_wr),
    .prog_fuse_sel(prog_fuse_sel),
    .prog_serial(prog_serial),
    .prog_data(prog_data),
    .prog_lock_wr(prog_lock_wr),
    .prog_chip_erase(prog_chip_erase),
    .lock_byte(lock_byte),
    .fuse_low(fuse_low),
    .fuse_high(fuse_high),
    .fuse_ext(fuse_ext),
    .busy(nv_busy),
    .done(nv_done)
  );

  // Only five codes take effect; anything else is dropped silently
  always_comb begin
    unique case (ctrl_wdata[4:0])
      fuse_lock_pkg::CMD_BUF_CLEAR,
      fuse_lock_pkg::CMD_READ_CFG,
      fuse_lock_pkg::CMD_PAGE_WRITE,
      fuse_lock_pkg::CMD_PAGE_ERASE,
      fuse_lock_pkg::CMD_BUF_FILL: cmd_valid = 1'b1;
      default: cmd_valid = 1'b0;
    endcase
  end

  // EEPROM writes and self-writes lock out control writes
  assign ctrl_accept = ctrl_wr && cmd_valid && !eeprom_write_busy && !nv_busy;
  assign win_start = ctrl_accept;
  // Readback window is the shorter load window
  assign win_len = (ctrl_wdata[4:0] == fuse_lock_pkg::CMD_READ_CFG) ?
                   fuse_lock_pkg::LOAD_WINDOW : fuse_lock_pkg::STORE_WINDOW;
  assign read_armed = win_open && (cur.ctrl == fuse_lock_pkg::CMD_READ_CFG);

  // Instruction handling and auto-clear of the control flags
  always_comb begin
    next_cur = cur;
    next_cur.load_valid = 1'b0;
    next_cur.load_cfg = 1'b0;
    next_cur.fill = 1'b0;
    next_cur.clr = 1'b0;
    nv_start = fuse_lock_pkg::NV_IDLE;
    win_close = 1'b0;
    finish = 1'b0;
    if (load_req) begin
      next_cur.load_valid = 1'b1;
      // EEPROM busy degrades the load to a normal flash read
      if (read_armed && !eeprom_write_busy) begin
        next_cur.load_cfg = 1'b1;
        finish = 1'b1;
        // Stored bits are already zero for programmed cells
        unique case (load_addr)
          fuse_lock_pkg::ADDR_LOCK: next_cur.load_data = lock_byte;
          fuse_lock_pkg::ADDR_LOW_FUSE: next_cur.load_data = fuse_low;
          fuse_lock_pkg::ADDR_HIGH_FUSE: next_cur.load_data = fuse_high;
          default: next_cur.load_data = fuse_lock_pkg::UNPROG_BYTE;
        endcase
      end else begin
        next_cur.load_data = flash_rdata;
      end
    end
    // Stores need the self-program fuse and a quiet EEPROM
    if (store_req && win_open && self_program_allowed && !eeprom_write_busy) begin
      unique case (cur.ctrl)
        fuse_lock_pkg::CMD_PAGE_ERASE: begin
          nv_start = fuse_lock_pkg::NV_ERASE;
          win_close = 1'b1;
        end
        fuse_lock_pkg::CMD_PAGE_WRITE: begin
          nv_start = fuse_lock_pkg::NV_WRITE;
          win_close = 1'b1;
        end
        fuse_lock_pkg::CMD_READ_CFG: begin
          nv_start = fuse_lock_pkg::NV_LOCK;
          win_close = 1'b1;
        end
        fuse_lock_pkg::CMD_BUF_FILL: begin
          next_cur.fill = 1'b1;
          finish = 1'b1;
        end
        fuse_lock_pkg::CMD_BUF_CLEAR: begin
          next_cur.clr = 1'b1;
          finish = 1'b1;
        end
        default: ;
      endcase
    end
    if (finish) begin
      win_close = 1'b1;
    end
    // Flags stay up through a self-write and drop when it ends
    if (finish || win_expire || nv_done) begin
      next_cur.ctrl = fuse_lock_pkg::CTRL_IDLE;
    end
    // A new command wins over any clear in the same cycle
    if (ctrl_accept) begin
      next_cur.ctrl = ctrl_wdata[4:0];
    end
  end

  // Control state follows the core reset
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      cur <= '0;
    end else if (clk_en) begin
      cur <= next_cur;
    end
  end

  // Register read and instruction results
  assign ctrl_rdata = {3'h0, cur.ctrl};
  assign load_data = cur.load_data;
  assign load_valid = cur.load_valid;
  assign load_from_config = cur.load_cfg;
  assign page_buffer_fill = cur.fill;
  assign page_buffer_clear = cur.clr;
  assign cpu_halt = nv_busy;

  // Protection decode; both lock bits high means no protection at all
  assign flash_prog_allow = lock_byte[fuse_lock_pkg::LOCK_LOW_BIT];
  assign flash_verify_allow = lock_byte[fuse_lock_pkg::LOCK_LOW_BIT] ||
                              lock_byte[fuse_lock_pkg::LOCK_HIGH_BIT];
  assign fuse_change_allow = lock_byte[fuse_lock_pkg::LOCK_LOW_BIT];
  // Costs sleep current; debug needs the clock alive
  assign clock_keep_in_sleep = !fuse_high[fuse_lock_pkg::DEBUG_LINK_BIT];
  assign self_program_allowed = !fuse_ext[fuse_lock_pkg::SELF_PROG_FUSE_BIT];

  // Checks
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_n || !power_on_rst_n);

  logic cfg_take;
  assign cfg_take = clk_en && load_req && read_armed && !eeprom_write_busy;

  lock_readback_a: assert property (
    cfg_take && load_addr == fuse_lock_pkg::ADDR_LOCK |=>
    load_from_config && load_data == lock_byte)
    else $error("lock readback wrong");
  low_fuse_read_a: assert property (
    cfg_take && load_addr == fuse_lock_pkg::ADDR_LOW_FUSE |=> load_data == fuse_low)
    else $error("low fuse readback wrong");
  high_fuse_read_a: assert property (
    cfg_take && load_addr == fuse_lock_pkg::ADDR_HIGH_FUSE |=> load_data == fuse_high)
    else $error("high fuse readback wrong");
  bad_addr_ones_a: assert property (
    cfg_take && load_addr != fuse_lock_pkg::ADDR_LOCK &&
    load_addr != fuse_lock_pkg::ADDR_LOW_FUSE && load_addr != fuse_lock_pkg::ADDR_HIGH_FUSE
    |=> load_data == fuse_lock_pkg::UNPROG_BYTE)
    else $error("unknown pointer not all ones");
  readback_clears_a: assert property (
    cfg_take && !ctrl_wr |=> ctrl_rdata == 8'h00 && !win_open)
    else $error("flags not cleared after readback");
  read_timeout_a: assert property (
    clk_en && ctrl_accept && ctrl_wdata[4:0] == fuse_lock_pkg::CMD_READ_CFG ##1
    (clk_en && !load_req && !store_req && !ctrl_wr)[*3] |=> ctrl_rdata == 8'h00)
    else $error("flags not cleared after three idle cycles");
  flash_passthru_a: assert property (
    clk_en && load_req && !read_armed |=>
    !load_from_config && load_data == $past(flash_rdata))
    else $error("unarmed load not passed through");
  eeprom_block_a: assert property (
    clk_en && load_req && eeprom_write_busy |=> !load_from_config)
    else $error("readback during eeprom write");
  lock_unused_a: assert property (
    lock_byte[7:2] == fuse_lock_pkg::LOCK_UNUSED_ONES[7:2])
    else $error("unused lock bits not one");
  erase_effect_a: assert property (
    clk_en && prog_chip_erase |=> lock_byte == fuse_lock_pkg::UNPROG_BYTE &&
    $stable(fuse_low) && $stable(fuse_high) && $stable(fuse_ext))
    else $error("chip erase effect wrong");
  fuse_frozen_a: assert property (
    !lock_byte[fuse_lock_pkg::LOCK_LOW_BIT] |=>
    $stable(fuse_low) && $stable(fuse_high) && $stable(fuse_ext))
    else $error("fuse changed while locked");
  mode_three_a: assert property (
    lock_byte[1:0] == 2'h0 |->
    !flash_prog_allow && !flash_verify_allow && !fuse_change_allow)
    else $error("mode three not fully protected");
  serial_keep_a: assert property (
    clk_en && prog_fuse_wr && prog_serial && prog_fuse_sel == fuse_lock_pkg::FUSE_SEL_HIGH
    |=> $stable(fuse_high[fuse_lock_pkg::SERIAL_PROG_FUSE_BIT]))
    else $error("serial enable fuse changed serially");
  halt_length_a: assert property ($rose(cpu_halt) |-> cpu_halt[*8])
    else $error("self write ended too soon");
  // A core reset clears the flags mid-write, so its own cycle is left out
  ctrl_hold_a: assert property (cpu_halt && !nv_done && rst_n |=> $stable(ctrl_rdata))
    else $error("control flags moved during self write");

  readback_c: cover property (cfg_take ##1 load_from_config);
  timeout_c: cover property (ctrl_accept ##1 !load_req [*3] ##1 ctrl_rdata == 8'h00);
  lock_write_c: cover property ($rose(cpu_halt) && ctrl_rdata[4:0] == fuse_lock_pkg::CMD_READ_CFG);
  locked_c: cover property (prog_fuse_wr && !fuse_change_allow);
  fill_c: cover property (store_req && win_open ##1 page_buffer_fill);
endmodule

// ===== sim/cpu_core_model.sv
// CPU core stand-in: writes the program-memory control register and then
// issues one load or store instruction a chosen number of cycles later.
// Assumes the bench calls its tasks from a single process.
`timescale 1ns/1ps
module cpu_core_model (
  input wire logic core_clk,
  output logic ctrl_wr,
  output logic [7:0] ctrl_wdata,
  output logic load_req,
  output logic [15:0] load_addr,
  output logic [7:0] flash_rdata,
  output logic store_req,
  output logic [7:0] store_data
);
  // Idle values at time zero
  initial begin
    ctrl_wr = 1'b0;
    ctrl_wdata = 8'h00;
    load_req = 1'b0;
    store_req = 1'b0;
    load_addr = 16'h0000;
    store_data = 8'h00;
    flash_rdata = 8'h00;
  end

  // Control write; released data is inverted so stale values never match
  task automatic ctrl_write(input logic [7:0] code);
    @(posedge core_clk);
    ctrl_wr <= 1'b1;
    ctrl_wdata <= code;
    @(posedge core_clk);
    ctrl_wr <= 1'b0;
    ctrl_wdata <= ~code;
  endtask

  // One instruction in cycle gap after the write; flash byte is addr xor 5a
  task automatic issue(input bit st, input int gap, input logic [15:0] a,
                       input logic [7:0] d);
    repeat (gap - 1) @(posedge core_clk);
    load_req <= !st;
    store_req <= st;
    load_addr <= a;
    store_data <= d;
    flash_rdata <= a[7:0] ^ 8'h5a;
    @(posedge core_clk);
    load_req <= 1'b0;
    store_req <= 1'b0;
    load_addr <= ~a;
    store_data <= ~d;
    flash_rdata <= ~(a[7:0] ^ 8'h5a);
  endtask
endmodule

// ===== sim/fuse_lock_readback_protect_tb.sv
// Self-checking bench for the fuse and lock readback block.
// Assumes the CPU model drives the instruction side; the bench plays programmer.
`timescale 1ns/1ps
module fuse_lock_readback_protect_tb;
  logic core_clk, rst_n, power_on_rst_n, clk_en, eeprom_write_busy;
  logic prog_fuse_wr, prog_serial, prog_lock_wr, prog_chip_erase;
  fuse_lock_pkg::fuse_sel_t prog_fuse_sel;
  logic [7:0] prog_data, ctrl_wdata, flash_rdata, store_data, ctrl_rdata, load_data;
  logic [7:0] lock_byte, fuse_low, fuse_high, fuse_ext;
  logic [15:0] load_addr;
  logic ctrl_wr, load_req, store_req, load_valid, load_from_config, fill, clr, cpu_halt;
  logic flash_prog_allow, flash_verify_allow, fuse_change_allow, keep_clk, self_ok;
  int err_count = 0;
  int checked = 0;

  // Short self-write so the halt can be counted in full
  fuse_lock_readback_protect #(.NV_WRITE_CYCLES(20)) fuse_lock_readback_protect_inst (
    .core_clk(core_clk), .rst_n(rst_n), .power_on_rst_n(power_on_rst_n), .clk_en(clk_en),
    .ctrl_wr(ctrl_wr), .ctrl_wdata(ctrl_wdata), .ctrl_rdata(ctrl_rdata),
    .load_req(load_req), .load_addr(load_addr), .flash_rdata(flash_rdata),
    .load_data(load_data), .load_valid(load_valid), .load_from_config(load_from_config),
    .store_req(store_req), .store_data(store_data), .page_buffer_fill(fill),
    .page_buffer_clear(clr), .cpu_halt(cpu_halt), .eeprom_write_busy(eeprom_write_busy),
    .prog_fuse_wr(prog_fuse_wr), .prog_fuse_sel(prog_fuse_sel), .prog_serial(prog_serial),
    .prog_data(prog_data), .prog_lock_wr(prog_lock_wr), .prog_chip_erase(prog_chip_erase),
    .lock_byte(lock_byte), .fuse_low(fuse_low), .fuse_high(fuse_high), .fuse_ext(fuse_ext),
    .flash_prog_allow(flash_prog_allow), .flash_verify_allow(flash_verify_allow),
    .fuse_change_allow(fuse_change_allow), .clock_keep_in_sleep(keep_clk),
    .self_program_allowed(self_ok));

  cpu_core_model cpu_core_model_inst (
    .core_clk(core_clk), .ctrl_wr(ctrl_wr), .ctrl_wdata(ctrl_wdata), .load_req(load_req),
    .load_addr(load_addr), .flash_rdata(flash_rdata), .store_req(store_req),
    .store_data(store_data));

  // 250 MHz clock
  initial begin
    core_clk = 1'b0;
    forever #2 core_clk = ~core_clk;
  end

  // Compare and count; four-state equality so unknowns never match
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    checked++;
    if (got !== exp) begin
      err_count++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // Armed readback with the load in cycle gap after the control write
  task automatic rd(input int gap, input logic [15:0] a, input logic cfg,
                    input logic [7:0] d);
    cpu_core_model_inst.ctrl_write(8'h09);
    cpu_core_model_inst.issue(1'b0, gap, a, 8'h00);
    #1;
    chk(load_valid, 1'b1);
    chk(load_from_config, cfg);
    chk(load_data, d);
  endtask

  // One programming pulse: kind bit0 fuse write, bit1 lock write, bit2 erase
  task automatic prog(input logic [2:0] kind, input logic [1:0] sel, input logic ser,
                      input logic [7:0] d);
    @(posedge core_clk);
    {prog_chip_erase, prog_lock_wr, prog_fuse_wr} <= kind;
    prog_fuse_sel <= fuse_lock_pkg::fuse_sel_t'(sel);
    prog_serial <= ser;
    prog_data <= d;
    @(posedge core_clk);
    {prog_chip_erase, prog_lock_wr, prog_fuse_wr} <= 3'h0;
    #1;
  endtask

  // Power-up contents read back through the armed load, except the extended fuse, which is checked directly
  task automatic t_defaults;
    chk(fuse_ext, 8'hff);
    rd(1, 16'h0000, 1'b1, 8'h64);
    chk(ctrl_rdata, 8'h00);
    rd(2, 16'h0001, 1'b1, 8'hff);
    rd(3, 16'h0003, 1'b1, 8'hdf);
    rd(1, 16'h0002, 1'b1, 8'hff);
    chk({flash_prog_allow, flash_verify_allow, fuse_change_allow}, 3'h7);
  endtask

  // Unlisted code ignored; window expiry falls back to flash
  task automatic t_window;
    cpu_core_model_inst.ctrl_write(8'h08);
    #1;
    chk(ctrl_rdata, 8'h00);
    cpu_core_model_inst.ctrl_write(8'h09);
    #1;
    chk(ctrl_rdata, 8'h09);
    repeat (3) @(posedge core_clk);
    #1;
    chk(ctrl_rdata, 8'h00);
    rd(4, 16'h0001, 1'b0, 8'h5b);
  endtask

  // EEPROM write in progress blocks readback
  task automatic t_eeprom;
    @(posedge core_clk);
    eeprom_write_busy <= 1'b1;
    rd(1, 16'h0000, 1'b0, 8'h5a);
    @(posedge core_clk);
    eeprom_write_busy <= 1'b0;
    // Armed first, then the EEPROM turns busy before the load arrives
    cpu_core_model_inst.ctrl_write(8'h09);
    eeprom_write_busy <= 1'b1;
    cpu_core_model_inst.issue(1'b0, 1, 16'h0003, 8'h00);
    #1;
    chk({load_from_config, load_data}, 9'h059);
    @(posedge core_clk);
    eeprom_write_busy <= 1'b0;
  endtask

  // Fuses are set first, before any lock bit
  task automatic t_fuses;
    prog(3'h1, 2'h1, 1'b1, 8'h7f);
    chk(fuse_high, 8'h5f);
    chk(keep_clk, 1'b1);
    prog(3'h1, 2'h1, 1'b0, 8'hdf);
    prog(3'h1, 2'h2, 1'b0, 8'hfe);
    chk(self_ok, 1'b1);
  endtask

  // Fill pulses once at the window's last cycle, clear at its first; erase halts with flags up
  task automatic t_buffer;
    cpu_core_model_inst.ctrl_write(8'h01);
    cpu_core_model_inst.issue(1'b1, 4, 16'h0000, 8'h00);
    #1;
    chk({fill, clr, ctrl_rdata}, 10'h200);
    cpu_core_model_inst.ctrl_write(8'h11);
    cpu_core_model_inst.issue(1'b1, 1, 16'h0000, 8'h00);
    #1;
    chk({fill, clr, ctrl_rdata}, 10'h100);
    cpu_core_model_inst.ctrl_write(8'h03);
    cpu_core_model_inst.issue(1'b1, 4, 16'h0000, 8'h00);
    #1;
    chk({cpu_halt, ctrl_rdata}, 9'h103);
    repeat (20) @(posedge core_clk);
    #1;
    chk({cpu_halt, ctrl_rdata}, 9'h000);
  endtask

  // Mode two, refused fuse change, erase restores locks only
  task automatic t_locks;
    prog(3'h2, 2'h0, 1'b0, 8'hfe);
    chk({flash_prog_allow, flash_verify_allow, fuse_change_allow}, 3'h2);
    prog(3'h1, 2'h0, 1'b0, 8'h00);
    chk(fuse_low, 8'h64);
    rd(1, 16'h0001, 1'b1, 8'hfe);
    prog(3'h2, 2'h0, 1'b0, 8'hff);
    chk(lock_byte, 8'hfe);
    prog(3'h4, 2'h0, 1'b0, 8'h00);
    chk(lock_byte, 8'hff);
    chk({fuse_ext, fuse_high}, 16'hfedf);
  endtask

  // Lock write by store: full timed halt survives a core reset mid-way
  task automatic t_selfwrite;
    int n;
    n = 0;
    cpu_core_model_inst.ctrl_write(8'h09);
    cpu_core_model_inst.issue(1'b1, 1, 16'h0001, 8'hfc);
    for (int i = 0; i < 40; i++) begin
      #1;
      if (cpu_halt === 1'b1) n++;
      @(posedge core_clk);
      rst_n <= (i != 5);
    end
    chk(n, 20);
    chk(lock_byte, 8'hfc);
    chk({flash_prog_allow, flash_verify_allow, fuse_change_allow}, 3'h0);
  endtask

  // Verdict and end of run
  task automatic final_report;
    if (err_count == 0 && checked > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  // Hang guard at 5000 cycles, far beyond the under two hundred cycles the run needs
  initial begin
    #20000;
    err_count++;
    final_report();
  end

  // Reset for three cycles, then the scenarios in order
  initial begin
    {rst_n, power_on_rst_n, eeprom_write_busy} = 3'h0;
    clk_en = 1'b1;
    {prog_fuse_wr, prog_serial, prog_lock_wr, prog_chip_erase} = 4'h0;
    prog_fuse_sel = fuse_lock_pkg::FUSE_SEL_LOW;
    prog_data = 8'h00;
    repeat (3) @(posedge core_clk);
    rst_n <= 1'b1;
    power_on_rst_n <= 1'b1;
    t_defaults();
    t_window();
    t_eeprom();
    t_fuses();
    t_buffer();
    t_locks();
    t_selfwrite();
    final_report();
  end
endmodule
